// [design/tmw_timer16.sv]
// What this block does
// [RULE_01] counting depends only on waveform mode
// [RULE_02] mode 0 counts up, wraps to zero
// [RULE_03] normal overflow flag set when count hits zero
// [RULE_04] counter writable any time in normal mode
// [RULE_05] clear-on-match clears at compare A or capture
// [RULE_06] clear-on-match top unbuffered, missed top wraps
// [RULE_07] clear-on-match sets top register's flag
// [RULE_08] clear-on-match toggle mode flips output A
// [RULE_09] clear-on-match overflow at max-to-zero rollover
// [RULE_10] modes 5,6,7,14,15 are fast PWM
// [RULE_11] fast PWM top choice; clear after top
// [RULE_12] PWM mode 2 clear-on-match, 3 inverse
// [RULE_13] fast PWM overflow and top flag at top
// [RULE_14] fixed top masks compare writes
// [RULE_15] fast PWM capture top unbuffered
// [RULE_16] fast PWM compare buffered, loaded at top
// [RULE_17] compare zero spikes, compare top constant
// [RULE_18] mode 15 toggle gives square wave A
// [RULE_19] software keeps top above compares
// [RULE_20] prescaled tick, divisors 1 to 1024
// [RULE_21] software keeps variable top at least three
// [RULE_22] reset clears output compare state
// [RULE_23] counter write blocks next compare match
// [RULE_24] writing one clears overflow flag
//
// The implementer's own choices: the register addresses and strobed register access.
module tmw_timer16
  import tmw_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [15:0]       rdata,
  output logic                   wave_out_a,
  output logic                   wave_out_a_oe,
  output logic                   wave_out_b,
  output logic                   wave_out_b_oe,
  output logic      [3:0]        flags
);
  import tmw_pkg::*;

  tmw_state_t s;
  tmw_state_t n;

  function automatic logic is_fast(input logic [3:0] m);
    return (m == WGM_FAST_8) || (m == WGM_FAST_9) || (m == WGM_FAST_10) ||
           (m == WGM_FAST_CAP) || (m == WGM_FAST_A); // see [RULE_10]
  endfunction

  function automatic logic [15:0] fixed_mask(input logic [3:0] m);
    case (m)
      WGM_FAST_8: begin
        return TOP_8;
      end
      WGM_FAST_9: begin
        return TOP_9;
      end
      WGM_FAST_10: begin
        return TOP_10;
      end
      default: begin
        return CNT_MAX;
      end
    endcase
  endfunction

  function automatic logic [1:0] wave_step(input logic [3:0] m, input logic [1:0] com,
                                           input logic oc, input logic match,
                                           input logic at_top);
    logic [1:0] r;
    r = {oc, 1'b0};
    if (is_fast(m)) begin
      // fast pwm: compare action, bottom action; compare match wins when cmp==top
      if (com == COM_TGL && m == WGM_FAST_A && match) begin
        r[1] = ~oc; // see [RULE_18]
      end else if (com == COM_NINV || com == COM_INV) begin
        if (at_top) begin
          r[1] = (com == COM_NINV); // see [RULE_12]
        end
        if (match) begin
          r[1] = (com == COM_INV); // see [RULE_17]
        end
      end
    end else if (match) begin
      case (com)
        COM_TGL: begin
          r[1] = ~oc; // see [RULE_08]
        end
        COM_NINV: begin
          r[1] = 1'b0;
        end
        COM_INV: begin
          r[1] = 1'b1;
        end
        default: begin
          r[1] = oc;
        end
      endcase
    end
    return r;
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] fix,
                                          input logic [15:0] ca, input logic [15:0] cp);
    logic [15:0] r;
    case (m)
      WGM_FAST_8, WGM_FAST_9, WGM_FAST_10: begin
        r = fix; // see [RULE_11]
      end
      WGM_CTC_A, WGM_FAST_A: begin
        r = ca; // see [RULE_05]
      end
      WGM_CTC_CAP, WGM_FAST_CAP: begin
        r = cp; // see [RULE_15]
      end
      default: begin
        r = CNT_MAX; // see [RULE_02]
      end
    endcase
    return r;
  endfunction

  // divider runs free, so a new divisor may give a short first period
  function automatic logic presc_tick(input logic [2:0] k, input logic [9:0] p);
    logic r;
    case (k)
      CKS_1: begin
        r = 1'b1;
      end
      CKS_8: begin
        r = (p[2:0] == DIV_8_M1[2:0]);
      end
      CKS_64: begin
        r = (p[5:0] == DIV_64_M1[5:0]);
      end
      CKS_256: begin
        r = (p[7:0] == DIV_256_M1[7:0]);
      end
      CKS_1024: begin
        r = (p == DIV_1024_M1);
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  function automatic logic [15:0] pack_ctrl(input tmw_state_t st);
    logic [15:0] r;
    r = 16'h0000;
    r[WGM_LSB +: 4]  = st.wgm;
    r[CKS_LSB +: 3]  = st.cks;
    r[COMA_LSB +: 2] = st.com_a;
    r[COMB_LSB +: 2] = st.com_b;
    r[DIRA_BIT]      = st.dir_a;
    r[DIRB_BIT]      = st.dir_b;
    return r;
  endfunction

  function automatic logic top_from_a(input logic [3:0] m);
    return (m == WGM_CTC_A) || (m == WGM_FAST_A);
  endfunction

  function automatic logic top_from_cap(input logic [3:0] m);
    return (m == WGM_CTC_CAP) || (m == WGM_FAST_CAP);
  endfunction

  // write-one-to-clear, but a flag raised by hardware this cycle survives
  function automatic logic [3:0] after_clear(input logic [3:0] cur, input logic [3:0] hw_set,
                                             input logic [3:0] w1);
    logic [3:0] r;
    r = cur;
    for (int i = 0; i < 4; i++) begin
      if (w1[i] && !hw_set[i]) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

  logic        tick;
  logic [15:0] top;
  logic        var_top_a;
  logic        var_top_cap;
  logic        fast;
  logic        hit_top;
  logic        match_a;
  logic        match_b;
  logic [15:0] mask;
  logic [1:0]  step_a;
  logic [1:0]  step_b;
  logic [3:0]  flag_set;

  always_comb begin
    n = s;
    fast = is_fast(s.wgm);
    mask = fixed_mask(s.wgm);
    var_top_a = top_from_a(s.wgm);
    var_top_cap = top_from_cap(s.wgm);
    top = top_of(s.wgm, mask, s.cmp_a, s.cap);

    // prescaler: one tick per divisor period
    tick = presc_tick(s.cks, s.pre); // see [RULE_20]
    if (s.cks == CKS_STOP || s.cks > CKS_1024) begin
      n.pre = s.pre;
    end else begin
      n.pre = s.pre + 10'h001;
    end

    // only modes with a real top clear early; the others wrap like normal mode
    hit_top = (fast || var_top_a || var_top_cap) && (s.count == top) && !s.block;
    match_a = (s.count == s.cmp_a) && !s.block; // see [RULE_23]
    match_b = (s.count == s.cmp_b) && !s.block;
    flag_set = 4'h0;
    if (tick) begin
      n.block = 1'b0;
    end

    if (tick) begin
      // mode selector alone drives the count sequence; com fields only steer the output steps below
      if (hit_top) begin
        n.count = CNT_ZERO; // see [RULE_01]
        if (fast) begin
          flag_set[FLG_OVF] = 1'b1; // see [RULE_13]
          n.cmp_a = s.cmp_a_buf; // see [RULE_16]
          n.cmp_b = s.cmp_b_buf;
        end else if (s.count == CNT_MAX) begin
          flag_set[FLG_OVF] = 1'b1; // see [RULE_09]
        end
        if (var_top_cap) begin
          flag_set[FLG_CAP] = 1'b1; // see [RULE_07]
        end
      end else begin
        n.count = s.count + 16'h0001; // see [RULE_06]
        if (s.count == CNT_MAX) begin
          flag_set[FLG_OVF] = 1'b1; // see [RULE_03] [RULE_09]
        end
      end
      if (match_a) begin
        flag_set[FLG_CMPA] = 1'b1;
      end
      if (match_b) begin
        flag_set[FLG_CMPB] = 1'b1;
      end
      step_a = wave_step(s.wgm, s.com_a, s.oc_a, match_a, hit_top);
      step_b = wave_step(s.wgm, (s.com_b == COM_TGL) ? COM_OFF : s.com_b, s.oc_b,
                         match_b, hit_top);
      n.oc_a = step_a[1];
      n.oc_b = step_b[1];
    end else begin
      step_a = 2'h0;
      step_b = 2'h0;
    end
    // sticky flags: a hardware set always beats a software clear
    n.flags = s.flags | flag_set;

    n.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        ADDR_CTRL: begin
          n.rdata = pack_ctrl(s);
        end
        ADDR_COUNT: begin
          n.rdata = s.count;
        end
        ADDR_CMP_A: begin
          n.rdata = fast ? s.cmp_a_buf : s.cmp_a;
        end
        ADDR_CMP_B: begin
          n.rdata = fast ? s.cmp_b_buf : s.cmp_b;
        end
        ADDR_CAPTURE: begin
          n.rdata = s.cap;
        end
        ADDR_FLAGS: begin
          n.rdata = {12'h000, s.flags};
        end
        default: begin
          n.rdata = 16'h0000;
        end
      endcase
    end

    if (wr) begin
      case (addr)
        ADDR_CTRL: begin
          n.wgm   = wdata[WGM_LSB +: 4];
          n.cks   = wdata[CKS_LSB +: 3];
          n.com_a = wdata[COMA_LSB +: 2];
          n.com_b = wdata[COMB_LSB +: 2];
          n.dir_a = wdata[DIRA_BIT];
          n.dir_b = wdata[DIRB_BIT];
        end
        ADDR_COUNT: begin
          n.count = wdata; // see [RULE_04]
          n.block = 1'b1; // see [RULE_23]
        end
        ADDR_CMP_A: begin
          n.cmp_a_buf = wdata & mask; // see [RULE_14]
          if (!fast)
            n.cmp_a = wdata & mask; // see [RULE_06]
        end
        ADDR_CMP_B: begin
          n.cmp_b_buf = wdata & mask;
          if (!fast)
            n.cmp_b = wdata & mask;
        end
        ADDR_CAPTURE: begin
          n.cap = wdata; // see [RULE_15]
        end
        ADDR_FLAGS: begin
          n.flags = after_clear(n.flags, flag_set, wdata[3:0]); // see [RULE_24]
        end
        default: begin
        end
      endcase
    end

    // pin driven only with direction set; port value low when not overridden
    // new mode field used so the pin drops in the same cycle it is switched off
    if (n.com_a != COM_OFF) begin
      n.pin_a = n.oc_a; // see [RULE_08]
    end else begin
      n.pin_a = 1'b0;
    end
    n.pin_oe_a = n.dir_a;
    if (n.com_b != COM_OFF) begin
      n.pin_b = n.oc_b;
    end else begin
      n.pin_b = 1'b0;
    end
    n.pin_oe_b = n.dir_b;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0; // see [RULE_22]
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign wave_out_a = s.pin_a;
  assign wave_out_a_oe = s.pin_oe_a;
  assign wave_out_b = s.pin_b;
  assign wave_out_b_oe = s.pin_oe_b;
  assign flags = s.flags;
endmodule

// [design/tmw_pkg.sv]
package tmw_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_COUNT   = 4'h1;
  localparam logic [3:0] ADDR_CMP_A   = 4'h2;
  localparam logic [3:0] ADDR_CMP_B   = 4'h3;
  localparam logic [3:0] ADDR_CAPTURE = 4'h4;
  localparam logic [3:0] ADDR_FLAGS   = 4'h5;
  // ctrl fields
  localparam int unsigned WGM_LSB  = 0;
  localparam int unsigned CKS_LSB  = 4;
  localparam int unsigned COMA_LSB = 8;
  localparam int unsigned COMB_LSB = 10;
  localparam int unsigned DIRA_BIT = 12;
  localparam int unsigned DIRB_BIT = 13;
  // flag bits
  localparam int unsigned FLG_OVF  = 0;
  localparam int unsigned FLG_CMPA = 1;
  localparam int unsigned FLG_CMPB = 2;
  localparam int unsigned FLG_CAP  = 3;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] TOP_8    = 16'h00ff;
  localparam logic [15:0] TOP_9    = 16'h01ff;
  localparam logic [15:0] TOP_10   = 16'h03ff;
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CTC_A    = 4'h4;
  localparam logic [3:0] WGM_FAST_8   = 4'h5;
  localparam logic [3:0] WGM_FAST_9   = 4'h6;
  localparam logic [3:0] WGM_FAST_10  = 4'h7;
  localparam logic [3:0] WGM_CTC_CAP  = 4'hc;
  localparam logic [3:0] WGM_FAST_CAP = 4'he;
  localparam logic [3:0] WGM_FAST_A   = 4'hf;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TGL = 2'h1;
  localparam logic [1:0] COM_NINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  // clock select: 0 stopped, 1..5 = /1,/8,/64,/256,/1024
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_1    = 3'h1;
  localparam logic [2:0] CKS_8    = 3'h2;
  localparam logic [2:0] CKS_64   = 3'h3;
  localparam logic [2:0] CKS_256  = 3'h4;
  localparam logic [2:0] CKS_1024 = 3'h5;
  localparam logic [9:0] DIV_8_M1    = 10'h007;
  localparam logic [9:0] DIV_64_M1   = 10'h03f;
  localparam logic [9:0] DIV_256_M1  = 10'h0ff;
  localparam logic [9:0] DIV_1024_M1 = 10'h3ff;

  typedef struct packed {
    logic [3:0]  wgm;
    logic [2:0]  cks;
    logic [1:0]  com_a;
    logic [1:0]  com_b;
    logic        dir_a;
    logic        dir_b;
    logic [9:0]  pre;
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b;
    logic [15:0] cmp_b_buf;
    logic [15:0] cap;
    logic [3:0]  flags;
    logic        block;
    logic        oc_a;
    logic        oc_b;
    logic        pin_a;
    logic        pin_oe_a;
    logic        pin_b;
    logic        pin_oe_b;
    logic [15:0] rdata;
  } tmw_state_t;
endpackage

// [verification/tmw_timer16_assertions.sv]
module tmw_timer16_chk
  import tmw_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        wave_out_a,
  input wire logic        wave_out_a_oe,
  input wire logic        wave_out_b,
  input wire logic        wave_out_b_oe,
  input wire logic [3:0]  flags
);
  // shadow of the control word, rebuilt from bus writes
  logic [15:0] ctrl;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctrl <= '0;
    else if (wr && addr == ADDR_CTRL) ctrl <= wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  pin_dir_a: assert property (
    {wave_out_b_oe, wave_out_a_oe} == ctrl[DIRB_BIT:DIRA_BIT]) else $error("oe mismatch");
  off_low_a: assert property (
    ctrl[COMA_LSB +: 2] == COM_OFF |-> !wave_out_a) else $error("pin a active in off mode");
  stop_hold_a: assert property (
    $past(ctrl[CKS_LSB +: 3] == CKS_STOP && !wr)
      |-> $stable(flags) && $stable({wave_out_a, wave_out_b}))
    else $error("activity while stopped");
  flag_w1c_a: assert property (
    |($past(flags) & ~flags) |-> $past(wr && addr == ADDR_FLAGS)
      && (($past(flags) & ~flags & ~$past(wdata[3:0])) == 4'h0))
    else $error("flag fell without write one");
  rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0) else $error("rdata not idle");
  rd_ctrl_a: assert property (
    rd && addr == ADDR_CTRL |=> rdata[13:0] == ctrl[13:0]) else $error("ctrl readback");
  rd_hole_a: assert property (
    rd && addr > ADDR_FLAGS |=> rdata == 16'h0) else $error("unmapped read not zero");
  one_strobe_a: assert property (
    rd ##1 !rd |=> rdata == 16'h0)
    else $error("rdata held too long");
endmodule

bind tmw_timer16 tmw_timer16_chk tmw_timer16_chk_inst (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wave_out_a(wave_out_a),
  .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe),
  .flags(flags));

// [verification/tmw_timer16_test.sv]
module tmw_timer16_test
  import tmw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
  logic [3:0]  flags;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          dv[5] = '{1, 8, 64, 256, 1024};
  tmw_timer16 tmw_timer16_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
    .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe), .flags(flags));
  initial forever #4 clk = ~clk;
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  function automatic logic [15:0] ctl(logic [3:0] m, logic [2:0] k, logic [1:0] ca,
                                      logic [1:0] cb);
    return {2'h0, 2'h3, cb, ca, 1'b0, k, m};
  endfunction
  // high cycles per period; compare at top wins over the bottom action
  function automatic int duty(int t, int c, bit inv);
    int h = (c == t) ? 0 : c + 1;
    return inv ? t + 1 - h : h;
  endfunction
  // skips the interval in progress, then times one full interval of pin a
  task automatic gap(output int n);
    logic b;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      b = wave_out_a;
      while (wave_out_a === b && n < 200) begin
        @(posedge clk);
        #1 n++;
      end
    end
  endtask
  initial begin
    logic [15:0] v, t, c;
    int n, k;
    void'($urandom(91));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rreg(ADDR_CTRL, v);
    chk(v, 16'h0);
    wreg(4'h9, 16'hffff);
    rreg(4'h9, v);
    chk(v, 16'h0);
    wreg(ADDR_CTRL, ctl(WGM_NORMAL, CKS_1, COM_OFF, COM_OFF));
    wreg(ADDR_COUNT, 16'hfffe);
    @(posedge clk);
    #1 chk({15'h0, flags[FLG_OVF]}, 16'h0);
    @(posedge clk);
    #1 chk({15'h0, flags[FLG_OVF]}, 16'h1);
    wreg(ADDR_FLAGS, 16'h0);
    #1 chk({15'h0, flags[FLG_OVF]}, 16'h1);
    wreg(ADDR_FLAGS, 16'h1);
    #1 chk({15'h0, flags[FLG_OVF]}, 16'h0);
    for (k = 0; k < 5; k++) begin
      wreg(ADDR_CTRL, ctl(WGM_NORMAL, 3'(k + 1), COM_OFF, COM_OFF));
      rreg(ADDR_COUNT, t);
      repeat (dv[k] * 3 - 2) @(posedge clk);
      rreg(ADDR_COUNT, v);
      chk(v - t, 16'h3);
    end
    for (k = 0; k < 3; k++) begin
      v = 16'($urandom());
      wreg(ADDR_CTRL, ctl(4'(5 + k), CKS_STOP, COM_OFF, COM_OFF));
      wreg(ADDR_CMP_B, v);
      rreg(ADDR_CMP_B, t);
      chk(t, v & ((16'h0100 << k) - 16'h1));
    end
    for (k = 0; k < 2; k++) begin
      t = 16'($urandom_range(20, 3));
      wreg(ADDR_CTRL, ctl(WGM_NORMAL, CKS_STOP, COM_OFF, COM_OFF));
      wreg(ADDR_CMP_A, t);
      wreg(ADDR_COUNT, 16'h0);
      wreg(ADDR_FLAGS, 16'hf);
      wreg(ADDR_CTRL, ctl(k ? WGM_FAST_A : WGM_CTC_A, CKS_1, COM_TGL, COM_OFF));
      gap(n);
      chk(16'(n), t + 16'h1);
      chk({14'h0, flags[1:0]}, k ? 16'h3 : 16'h2);
      // in clear-on-match the larger top is seen at once, else at the next top
      wreg(ADDR_CMP_A, t + 16'h5);
      gap(n);
      chk(16'(n), t + 16'h6);
    end
    for (k = 0; k < 6; k++) begin
      t = 16'($urandom_range(30, 3));
      c = (k % 3 == 0) ? 16'h0 : (k % 3 == 1) ? t : 16'($urandom_range(t - 1, 1));
      wreg(ADDR_CTRL, ctl(WGM_NORMAL, CKS_STOP, COM_OFF, COM_OFF));
      wreg(ADDR_COUNT, 16'h0);
      wreg(ADDR_CAPTURE, t);
      wreg(ADDR_CMP_B, c);
      wreg(ADDR_CTRL, ctl(WGM_FAST_CAP, CKS_1, COM_OFF, k < 3 ? COM_NINV : COM_INV));
      repeat (3 * t + 3) @(posedge clk);
      n = 0;
      repeat (2 * t + 2) begin
        @(posedge clk);
        #1 n += (wave_out_b === 1'b1);
      end
      chk(16'(n), 16'(2 * duty(t, c, k >= 3)));
    end
    close_out();
  end
endmodule
